// ===== rtl/usf_pkg.sv
// constants and types shared by both ends of the synchronous fifo port
// assumes a single 100 MHz system clock drives every flop of both ends
package usf_pkg;

    // ------------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_MHZ   = 100;
    localparam int unsigned IF_CLK_MHZ    = 60;
    // fractional divider: add step each system cycle, tick and wrap when the sum reaches mod
    localparam logic [7:0]  IF_ACC_MOD    = 8'(SYS_CLK_MHZ);
    localparam logic [7:0]  IF_ACC_STEP   = 8'(IF_CLK_MHZ);
    localparam logic [7:0]  IF_ACC_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // data path
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned FIFO_DEPTH    = 8;
    localparam logic [7:0]  BUS_IDLE_VAL  = 8'hFF;
    localparam logic [7:0]  DATA_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // state encodings (gray on each forward step; the return from sync to off or from xfer to idle flips both bits)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_CFG  = 2'h1,
        MODE_SYNC = 2'h3
    } usf_mode_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_OE   = 2'h1,
        RD_XFER = 2'h3
    } usf_rd_type;

endpackage : usf_pkg

// ===== rtl/usf_link_if.sv
// pin-level link between the device end and the fifo master end
// assumes both ends run on the same system clock; the shared data bus
// level is resolved here from the two output enables
interface usf_link_if;
    import usf_pkg::*;

    // ------------------------------------------------------------------
    // device driven pins
    // ------------------------------------------------------------------
    logic                interface_clock_out;
    logic                rx_data_available_n;
    logic                tx_space_available_n;
    logic                power_enabled_n;
    logic [DATA_W-1:0]   channel_a_data_dev;
    logic                channel_a_data_dev_oe;

    // ------------------------------------------------------------------
    // master driven pins
    // ------------------------------------------------------------------
    logic                bus_oe_n;
    logic                rd_strobe_n;
    logic                wr_strobe_n;
    logic                send_now_wake_n;
    logic [DATA_W-1:0]   channel_a_data_host;
    logic                channel_a_data_host_oe;

    // resolved bus, pulled high when nobody drives
    logic [DATA_W-1:0]   channel_a_data_bus;

    assign channel_a_data_bus = channel_a_data_dev_oe  ? channel_a_data_dev  :
                                channel_a_data_host_oe ? channel_a_data_host : BUS_IDLE_VAL;

    modport dev (
        output interface_clock_out, rx_data_available_n, tx_space_available_n, power_enabled_n,
        output channel_a_data_dev, channel_a_data_dev_oe,
        input  bus_oe_n, rd_strobe_n, wr_strobe_n, send_now_wake_n, channel_a_data_bus
    );

    modport host (
        input  interface_clock_out, rx_data_available_n, tx_space_available_n, power_enabled_n,
        input  channel_a_data_bus,
        output bus_oe_n, rd_strobe_n, wr_strobe_n, send_now_wake_n,
        output channel_a_data_host, channel_a_data_host_oe
    );

endinterface : usf_link_if

// ===== rtl/usf_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes depth is a power of two so the pointers wrap by themselves
module usf_fifo
    import usf_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_nrst,
    // fill side
    input  wire logic [WIDTH-1:0]           i_in_data,
    input  wire logic                       i_in_valid,
    output logic                            o_in_ready,
    // drain side
    output logic [WIDTH-1:0]                o_out_data,
    output logic                            o_out_valid,
    input  wire logic                       i_out_ready,
    // fill level
    output logic [$clog2(DEPTH):0]          o_count
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } usf_fifo_state_type;

    usf_fifo_state_type state_ff;
    usf_fifo_state_type nxt_state;
    logic               push;
    logic               pop;

    assign o_in_ready  = (state_ff.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (state_ff.cnt != '0);
    assign o_out_data  = state_ff.mem[state_ff.rp];
    assign o_count     = state_ff.cnt;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        nxt_state = state_ff;
        if (push) begin
            nxt_state.mem[state_ff.wp] = i_in_data;
            nxt_state.wp               = state_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_state.rp = state_ff.rp + 1'b1;
        end
        case ({push, pop})
            2'h2:    nxt_state.cnt = state_ff.cnt + 1'b1;
            2'h1:    nxt_state.cnt = state_ff.cnt - 1'b1;
            default: nxt_state.cnt = state_ff.cnt;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule : usf_fifo

// ===== rtl/usf_device_end.sv
// device end of the single-channel synchronous fifo port
// assumes the usb engine sits on the user-side ports and that the
// master on the link acts only in cycles where interface_clock_out is high
module usf_device_end
    import usf_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    // link to the fifo master
    usf_link_if.dev                    link,
    // configuration and usb state
    input  wire logic                  i_cfg_fifo_mode,
    input  wire logic                  i_bitmode_sync_req,
    input  wire logic                  i_usb_configured,
    input  wire logic                  i_usb_suspended,
    input  wire logic                  i_remote_wake_en,
    // bytes arriving from usb, bound for the master
    input  wire logic [DATA_W-1:0]     i_usb_rx_data,
    input  wire logic                  i_usb_rx_valid,
    output logic                       o_usb_rx_ready,
    // bytes from the master, bound for usb
    output logic [DATA_W-1:0]          o_usb_tx_data,
    output logic                       o_usb_tx_valid,
    input  wire logic                  i_usb_tx_ready,
    // mode and event outputs
    output logic                       o_sync_mode,
    output logic                       o_chan_b_disabled,
    output logic                       o_resume_req,
    output logic                       o_send_now
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        usf_mode_type      mode;
        logic [7:0]        acc;
        logic              clk_out;
        logic              hold_valid;
        logic [DATA_W-1:0] hold_data;
        logic              rxf_n;
        logic              txe_n;
        logic              dout_oe;
        logic              power_enabled_n_n;
        logic              snw_prev;
        logic              resume;
        logic              send_now;
        logic              sync_q;
    } usf_dev_state_type;

    localparam usf_dev_state_type DEV_RESET = '{
        mode:       MODE_OFF,
        acc:        IF_ACC_RESET,
        clk_out:    1'b0,
        hold_valid: 1'b0,
        hold_data:  DATA_RESET,
        rxf_n:      1'b1,
        txe_n:      1'b1,
        dout_oe:    1'b0,
        power_enabled_n_n:    1'b1,
        snw_prev:   1'b1,
        resume:     1'b0,
        send_now:   1'b0,
        sync_q:     1'b0
    };

    usf_dev_state_type state_ff;
    usf_dev_state_type nxt_state;

    // ------------------------------------------------------------------
    // fifo hookup
    // ------------------------------------------------------------------
    logic [DATA_W-1:0]            rxq_data;
    logic                         rxq_valid;
    logic                         rxq_pop;
    logic                         txq_push;
    logic [$clog2(FIFO_DEPTH):0]  txq_count;
    logic [8:0]                   acc_sum;
    logic                         tick;
    logic                         sync;
    logic                         rd_xfer;
    logic                         wr_xfer;
    logic                         snw_fall;
    logic [$clog2(FIFO_DEPTH)+1:0] txq_level;

    usf_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_in_data   (i_usb_rx_data),
        .i_in_valid  (i_usb_rx_valid),
        .o_in_ready  (o_usb_rx_ready),
        .o_out_data  (rxq_data),
        .o_out_valid (rxq_valid),
        .i_out_ready (rxq_pop),
        .o_count     ()
    );

    usf_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_in_data   (link.channel_a_data_bus),
        .i_in_valid  (txq_push),
        // room is tracked by the tx flag, which never lets the fifo overfill
        .o_in_ready  (),
        .o_out_data  (o_usb_tx_data),
        .o_out_valid (o_usb_tx_valid),
        .i_out_ready (i_usb_tx_ready),
        .o_count     (txq_count)
    );

    // ------------------------------------------------------------------
    // transfer qualifiers
    // ------------------------------------------------------------------
    // the registered clock-high cycle is the rising edge both ends act on
    assign tick     = state_ff.clk_out;
    assign sync     = (state_ff.mode == MODE_SYNC);
    assign rd_xfer  = tick && !state_ff.rxf_n && !link.rd_strobe_n;
    assign wr_xfer  = tick && !state_ff.txe_n && !link.wr_strobe_n;
    // refill the hold stage when empty or when its byte is being taken
    assign rxq_pop  = tick && sync && (!state_ff.hold_valid || rd_xfer);
    // txe was low only with room left, and the drain side only frees room
    assign txq_push = wr_xfer;
    assign snw_fall = tick && sync && state_ff.snw_prev && !link.send_now_wake_n;
    assign acc_sum  = {1'b0, state_ff.acc} + {1'b0, IF_ACC_STEP};
    assign txq_level = {1'b0, txq_count} + {{($clog2(FIFO_DEPTH)+1){1'b0}}, txq_push};

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state          = state_ff;
        nxt_state.resume   = 1'b0;
        nxt_state.send_now = 1'b0;

        // 60 MHz average rate out of 100 MHz; edge spacing jitters 1..2 cycles
        if (acc_sum >= {1'b0, IF_ACC_MOD}) begin
            nxt_state.acc     = 8'(acc_sum - {1'b0, IF_ACC_MOD});
            nxt_state.clk_out = 1'b1;
        end else begin
            nxt_state.acc     = acc_sum[7:0];
            nxt_state.clk_out = 1'b0;
        end

        // a bit-mode command before the config selects fifo mode is ignored
        case (state_ff.mode)
            MODE_OFF: begin
                if (i_cfg_fifo_mode) begin
                    nxt_state.mode = MODE_CFG;
                end
            end
            MODE_CFG: begin
                if (!i_cfg_fifo_mode) begin
                    nxt_state.mode = MODE_OFF;
                end else if (i_bitmode_sync_req) begin
                    nxt_state.mode = MODE_SYNC;
                end
            end
            MODE_SYNC: begin
                if (!i_cfg_fifo_mode) begin
                    nxt_state.mode = MODE_OFF;
                end
            end
            default: nxt_state.mode = MODE_OFF;
        endcase

        nxt_state.sync_q  = (nxt_state.mode == MODE_SYNC);
        nxt_state.power_enabled_n_n = !(i_usb_configured && !i_usb_suspended);

        // rx and tx flags and the hold data move only on interface clock edges
        if (tick) begin
            if (rd_xfer) begin
                nxt_state.hold_valid = 1'b0;
            end
            if (rxq_pop && rxq_valid) begin
                nxt_state.hold_valid = 1'b1;
                nxt_state.hold_data  = rxq_data;
            end
            nxt_state.rxf_n = !(nxt_state.hold_valid && sync);
            // conservative: ignores a drain in this cycle, never overfills
            nxt_state.txe_n = !sync || (txq_level >= ($clog2(FIFO_DEPTH)+2)'(FIFO_DEPTH));
            nxt_state.snw_prev = link.send_now_wake_n;
        end

        if (snw_fall) begin
            if (state_ff.power_enabled_n_n) begin
                nxt_state.resume = i_remote_wake_en;
            end else begin
                nxt_state.send_now = 1'b1;
            end
        end

        // the master owns the bus unless it holds oe low in sync mode
        nxt_state.dout_oe = sync && !link.bus_oe_n;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= DEV_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.interface_clock_out   = state_ff.clk_out;
    assign link.rx_data_available_n   = state_ff.rxf_n;
    assign link.tx_space_available_n  = state_ff.txe_n;
    assign link.power_enabled_n       = state_ff.power_enabled_n_n;
    assign link.channel_a_data_dev    = state_ff.hold_data;
    assign link.channel_a_data_dev_oe = state_ff.dout_oe;
    assign o_sync_mode                = state_ff.sync_q;
    assign o_chan_b_disabled          = state_ff.sync_q;
    assign o_resume_req               = state_ff.resume;
    assign o_send_now                 = state_ff.send_now;

endmodule : usf_device_end

// ===== rtl/usf_host_end.sv
// fifo master end of the synchronous fifo port
// assumes it shares the system clock with the device end and acts only
// in cycles where interface_clock_out is high
module usf_host_end
    import usf_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    // link to the device
    usf_link_if.host                   link,
    // bytes to write into the device
    input  wire logic [DATA_W-1:0]     i_wr_data,
    input  wire logic                  i_wr_valid,
    output logic                       o_wr_ready,
    // bytes read from the device
    output logic [DATA_W-1:0]          o_rd_data,
    output logic                       o_rd_valid,
    input  wire logic                  i_rd_ready,
    // send-now or wake request and usb state
    input  wire logic                  i_send_now,
    output logic                       o_link_suspended
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        usf_rd_type        rd_state;
        logic              oe_n;
        logic              rd_n;
        logic              wr_n;
        logic [DATA_W-1:0] dout;
        logic              dout_oe;
        logic              tx_valid;
        logic [DATA_W-1:0] tx_data;
        logic              rx_valid;
        logic [DATA_W-1:0] rx_data;
        logic              snw_pend;
        logic              snw_n;
    } usf_host_state_type;

    localparam usf_host_state_type HOST_RESET = '{
        rd_state: RD_IDLE,
        oe_n:     1'b1,
        rd_n:     1'b1,
        wr_n:     1'b1,
        dout:     DATA_RESET,
        dout_oe:  1'b0,
        tx_valid: 1'b0,
        tx_data:  DATA_RESET,
        rx_valid: 1'b0,
        rx_data:  DATA_RESET,
        snw_pend: 1'b0,
        snw_n:    1'b1
    };

    usf_host_state_type state_ff;
    usf_host_state_type nxt_state;
    logic               tick;

    assign tick = link.interface_clock_out;

    always_comb begin
        nxt_state          = state_ff;
        nxt_state.snw_pend = state_ff.snw_pend || i_send_now;
        if (state_ff.rx_valid && i_rd_ready) begin
            nxt_state.rx_valid = 1'b0;
        end
        if (!state_ff.tx_valid && i_wr_valid) begin
            nxt_state.tx_valid = 1'b1;
            nxt_state.tx_data  = i_wr_data;
        end

        if (tick) begin
            // a write counts only where both it and the space flag were low
            if (!state_ff.wr_n && !link.tx_space_available_n) begin
                nxt_state.tx_valid = 1'b0;
            end
            case (state_ff.rd_state)
                RD_IDLE: begin
                    // pending writes win; oe goes low a full clock ahead of read
                    if (!link.rx_data_available_n && !state_ff.rx_valid && state_ff.wr_n
                        && !state_ff.tx_valid) begin
                        nxt_state.rd_state = RD_OE;
                        nxt_state.oe_n     = 1'b0;
                    end
                end
                RD_OE: begin
                    nxt_state.rd_state = RD_XFER;
                    nxt_state.rd_n     = 1'b0;
                end
                RD_XFER: begin
                    if (!state_ff.rd_n && !link.rx_data_available_n) begin
                        nxt_state.rx_valid = 1'b1;
                        nxt_state.rx_data  = link.channel_a_data_bus;
                    end
                    nxt_state.rd_state = RD_IDLE;
                    nxt_state.rd_n     = 1'b1;
                    nxt_state.oe_n     = 1'b1;
                end
                default: begin
                    nxt_state.rd_state = RD_IDLE;
                    nxt_state.rd_n     = 1'b1;
                    nxt_state.oe_n     = 1'b1;
                end
            endcase
            // drive only after the device has released the bus
            nxt_state.wr_n    = !(nxt_state.tx_valid && state_ff.oe_n && nxt_state.oe_n
                                  && (state_ff.rd_state == RD_IDLE));
            nxt_state.dout    = nxt_state.tx_data;
            nxt_state.dout_oe = !nxt_state.wr_n;
            // one clock-wide low strobe; a new request in this cycle is kept
            nxt_state.snw_n    = !state_ff.snw_pend;
            nxt_state.snw_pend = i_send_now;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= HOST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.bus_oe_n               = state_ff.oe_n;
    assign link.rd_strobe_n            = state_ff.rd_n;
    assign link.wr_strobe_n            = state_ff.wr_n;
    assign link.send_now_wake_n        = state_ff.snw_n;
    assign link.channel_a_data_host    = state_ff.dout;
    assign link.channel_a_data_host_oe = state_ff.dout_oe;
    assign o_wr_ready                  = !state_ff.tx_valid;
    assign o_rd_data                   = state_ff.rx_data;
    assign o_rd_valid                  = state_ff.rx_valid;
    assign o_link_suspended            = link.power_enabled_n;

endmodule : usf_host_end

// ===== testbench/usf_port_properties.sv
// link checks between the device end and the fifo master end
// assumes the bench wires it to the link interface signals
module usf_port_properties (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // link signals
    input wire logic interface_clock_out,
    input wire logic rx_data_available_n,
    input wire logic tx_space_available_n,
    input wire logic channel_a_data_dev_oe,
    input wire logic bus_oe_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic send_now_wake_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    // ----------------------------------------
    // link timing
    // ----------------------------------------
    a_dev_drive_oe: assert property (channel_a_data_dev_oe |-> !$past(bus_oe_n))
        else $error("device drives bus without output enable");
    a_oe_turn_on: assert property ($fell(bus_oe_n) |=> channel_a_data_dev_oe)
        else $error("device did not take the bus after enable");
    a_rx_flag_ticks: assert property (!interface_clock_out |=> $stable(rx_data_available_n))
        else $error("rx flag moved off an interface tick");
    a_tx_flag_ticks: assert property (!interface_clock_out |=> $stable(tx_space_available_n))
        else $error("tx flag moved off an interface tick");
    a_clk_no_gap: assert property (interface_clock_out ##1 !interface_clock_out |=> interface_clock_out)
        else $error("interface clock too slow");
    a_strobe_ticks: assert property (!interface_clock_out |=>
        $stable({bus_oe_n, rd_strobe_n, wr_strobe_n, send_now_wake_n}))
        else $error("master strobe moved off an interface tick");
    a_rd_after_oe: assert property ($fell(rd_strobe_n) |-> !$past(bus_oe_n))
        else $error("read strobe before output enable");
    a_wake_one_tick: assert property (interface_clock_out && !send_now_wake_n |=> send_now_wake_n)
        else $error("send now strobe longer than one tick");
    // reads, writes and wake strobes all seen
    c_read: cover property (interface_clock_out && !rx_data_available_n && !rd_strobe_n);
    c_write: cover property (interface_clock_out && !tx_space_available_n && !wr_strobe_n);
    c_wake: cover property ($fell(send_now_wake_n));
endmodule // usf_port_properties

// ===== testbench/usb_sync_fifo_port_bench.sv
// bench: device end and master end joined over the link interface
// assumes the rtl files and the checker are compiled first
module usb_sync_fifo_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       i_clk_sys = 0, i_nrst = 0, cfg = 0, bitm = 0, conf = 1, susp = 0, wake = 0, ok;
    logic       rxv = 0, txr = 0, wrv = 0, rdr = 0, snd = 0, rx_rdy, txv, sync, chb, res, snow, wr_rdy, rdv, lsus;
    logic [7:0] rxd = 8'h00, wrd = 8'h00, txd, rdd;
    int         mismatches = 0, n_compared = 0, n = 0;
    usf_link_if link ();
    usf_device_end usf_device_end_inst (.i_clk_sys, .i_nrst, .link, .i_cfg_fifo_mode(cfg), .i_bitmode_sync_req(bitm),
        .i_usb_configured(conf), .i_usb_suspended(susp), .i_remote_wake_en(wake), .i_usb_rx_data(rxd),
        .i_usb_rx_valid(rxv), .o_usb_rx_ready(rx_rdy), .o_usb_tx_data(txd), .o_usb_tx_valid(txv),
        .i_usb_tx_ready(txr), .o_sync_mode(sync), .o_chan_b_disabled(chb), .o_resume_req(res), .o_send_now(snow));
    usf_host_end usf_host_end_inst (.i_clk_sys, .i_nrst, .link, .i_wr_data(wrd), .i_wr_valid(wrv),
        .o_wr_ready(wr_rdy), .o_rd_data(rdd), .o_rd_valid(rdv), .i_rd_ready(rdr), .i_send_now(snd),
        .o_link_suspended(lsus));
    usf_port_properties usf_port_properties_inst (.i_clk_sys, .i_nrst, .interface_clock_out(link.interface_clock_out),
        .rx_data_available_n(link.rx_data_available_n), .tx_space_available_n(link.tx_space_available_n),
        .channel_a_data_dev_oe(link.channel_a_data_dev_oe), .bus_oe_n(link.bus_oe_n), .rd_strobe_n(link.rd_strobe_n),
        .wr_strobe_n(link.wr_strobe_n), .send_now_wake_n(link.send_now_wake_n));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic tick(input int k = 1);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // valid stays up after the last push; caller drops it as soon as its push loop ends
    task automatic push(input bit s, input logic [7:0] d, output logic k);
        int w = 0;
        rxv = s;
        wrv = !s;
        rxd = d;
        wrd = d;
        while (!(s ? rx_rdy : wr_rdy) && w < 60) begin
            tick();
            w++;
        end
        k = w < 60;
        if (k) tick();
    endtask
    task automatic get(input bit s, input int cnt, input logic [7:0] b);
        int w;
        for (int k = 0; k < cnt; k++) begin
            w = 0;
            while (!(s ? rdv : txv) && w < 60) begin
                tick();
                w++;
            end
            chk(s ? "rx_data" : "tx_data", b + 8'(k), s ? rdd : txd);
            tick();
        end
    endtask
    task automatic kick(input bit s, output logic g);
        int w = 0;
        snd = 1;
        tick();
        snd = 0;
        g = 0;
        while (!g && w < 40) begin
            tick();
            w++;
            g = s ? res : snow;
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
    initial begin
        tick(12);
        i_nrst = 1;
        bitm = 1;
        tick(3);
        chk("sync_mode", 8'h00, 8'(sync));
        chk("tx_space_n", 8'h01, 8'(link.tx_space_available_n));
        bitm = 0;
        cfg = 1;
        tick();
        bitm = 1;
        tick();
        bitm = 0;
        tick();
        chk("chan_b_off", 8'h01, 8'({sync, chb} == 2'b11));
        $display("test mode done");
        ok = 1;
        for (int i = 0; i < 12 && ok; i++) begin
            push(0, 8'h30 + 8'(i), ok);
            n += ok;
        end
        wrv = 0;
        chk("tx_count", 8'(usf_pkg::FIFO_DEPTH + 1), 8'(n));
        chk("tx_space_n", 8'h01, 8'(link.tx_space_available_n));
        txr = 1;
        get(0, n, 8'h30);
        tick(4);
        chk("tx_space_n", 8'h00, 8'(link.tx_space_available_n));
        $display("test write done");
        n = 0;
        ok = 1;
        for (int i = 0; i < 16 && ok; i++) begin
            push(1, 8'hC0 + 8'(i), ok);
            n += ok;
        end
        rxv = 0;
        chk("rx_count", 8'(usf_pkg::FIFO_DEPTH + 2), 8'(n));
        tick(8);
        chk("rx_avail_n", 8'h00, 8'(link.rx_data_available_n));
        rdr = 1;
        get(1, n, 8'hC0);
        tick(8);
        chk("rx_avail_n", 8'h01, 8'(link.rx_data_available_n));
        $display("test read done");
        kick(0, ok);
        chk("send_now", 8'h01, 8'(ok));
        chk("suspended", 8'h00, 8'(lsus));
        susp = 1;
        tick(4);
        chk("suspended", 8'h01, 8'(lsus));
        kick(1, ok);
        chk("resume_off", 8'h00, 8'(ok));
        wake = 1;
        kick(1, ok);
        chk("resume_req", 8'h01, 8'(ok));
        $display("test wake done");
        cfg = 0;
        tick(2);
        chk("sync_off", 8'h00, 8'(sync));
        chk("chan_b_on", 8'h00, 8'(chb));
        $display("test mode exit done");
        end_sim();
    end
endmodule // usb_sync_fifo_port_bench
